// ---- brownout_and_stack_reset_ctrl.sv ----
// reset-source controller: brown-out modes and stack overflow/underflow resets
// assumes the analog comparator outputs and cpu events are synchronous to sys_clk_i
//
// Notes on behaviour
// - Mode 11 keeps detection on always and holds start-up until ready with supply above threshold.
// - Mode 11 keeps protection in sleep and adds no brown-out delay to wake-up.
// - Mode 10 enables detection except in sleep and holds start-up until ready with supply good.
// - Mode 10 disables protection for the whole of sleep.
// - Mode 10 holds wake-up completion until the re-enabled detector is ready.
// - Mode 01 enables detection from the software brown-out enable bit.
// - Mode 01 releases start-up without waiting for ready or supply level.
// - Mode 01 applies brown-out resets only once the detector is ready after enabling.
// - The detector ready state is readable as the ready flag of the control register.
// - Mode 01 protection is unaltered by entering or leaving sleep.
// - With stack reset enabled, a push beyond level sixteen resets and sets the overflow flag.
// - With stack reset enabled, a pop below level one resets and sets the underflow flag.
// - The stack is 16 entries of 15 bits and flags record events whether or not reset is enabled.
`timescale 1ns/1ps
`include "brownout_stack_defines.svh"

module brownout_and_stack_reset_ctrl (
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic [1:0]               brownout_mode_cfg_i,
  input  wire logic                     stack_reset_enable_i,
  input  wire logic                     sw_brownout_enable_i,
  input  wire logic                     sleep_i,
  input  wire logic                     bod_ready_i,
  input  wire logic                     bod_trip_i,
  input  wire logic                     push_i,
  input  wire logic                     pop_i,
  input  wire logic [`STACK_WIDTH-1:0]  push_data_i,
  input  wire logic                     clear_overflow_i,
  input  wire logic                     clear_underflow_i,
  output logic      [`STACK_WIDTH-1:0]  top_data_o,
  output logic                          brownout_detect_en_o,
  output logic                          brownout_ready_flag_o,
  output logic                          stack_overflow_flag_o,
  output logic                          stack_underflow_flag_o,
  output logic                          reset_req_o,
  output logic                          startup_hold_o,
  output logic                          wake_hold_o,
  output logic                          sleeping_o
);

  brownout_stack_pkg::power_state_e state_r;
  brownout_stack_pkg::power_state_e state_nxt;

  logic detect_en;
  logic protect_en;
  logic bod_reset;
  logic stack_ovf_ev;
  logic stack_unf_ev;
  logic stack_reset;
  logic reset_req_r;
  logic startup_ok;

  // true for the modes that gate start-up on the detector
  function automatic logic mode_gates_startup(input logic [1:0] mode);
    mode_gates_startup = (mode == `BOD_MODE_ALWAYS) || (mode == `BOD_MODE_NOSLEEP);
  endfunction : mode_gates_startup

  // one-hot state test, shared by the enable decode and the hold outputs
  function automatic logic in_state(input brownout_stack_pkg::power_state_e cur,
                                    input brownout_stack_pkg::power_state_e want);
    in_state = (cur == want);
  endfunction : in_state

  // ===========================================================
  // detector enable and protection per mode
  // ===========================================================
  always_comb begin
    case (brownout_mode_cfg_i)
      `BOD_MODE_ALWAYS:  detect_en = 1'b1;
      `BOD_MODE_NOSLEEP: detect_en = !in_state(state_r, brownout_stack_pkg::ST_SLEEP);
      `BOD_MODE_SW:      detect_en = sw_brownout_enable_i;
      default:           detect_en = 1'b0;
    endcase
  end

  // protection only counts once the detector says ready, so a settling
  // comparator cannot fire a false reset just after it is switched on
  assign protect_en = detect_en & bod_ready_i;
  assign bod_reset  = protect_en & bod_trip_i;

  // start-up gate: gated modes need ready and supply above threshold
  assign startup_ok = mode_gates_startup(brownout_mode_cfg_i) ?
                      (bod_ready_i & ~bod_trip_i) : 1'b1;

  // ===========================================================
  // power sequencing state machine
  // ===========================================================
  // start-up waits on the gate, sleep follows sleep_i, and only the
  // off-in-sleep mode passes through a wake hold on the way back to run;
  // a reset request overrides all of it in the state register below
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      brownout_stack_pkg::ST_STARTUP: begin
        if (startup_ok) begin
          state_nxt = brownout_stack_pkg::ST_RUN;
        end
      end
      brownout_stack_pkg::ST_RUN: begin
        if (sleep_i) begin
          state_nxt = brownout_stack_pkg::ST_SLEEP;
        end
      end
      brownout_stack_pkg::ST_SLEEP: begin
        if (!sleep_i) begin
          // only off-in-sleep mode delays wake-up
          if (brownout_mode_cfg_i == `BOD_MODE_NOSLEEP) begin
            state_nxt = brownout_stack_pkg::ST_WAKE;
          end else begin
            state_nxt = brownout_stack_pkg::ST_RUN;
          end
        end
      end
      brownout_stack_pkg::ST_WAKE: begin
        // a ready left over from before sleep must not end the wake;
        // the detector has to be driven enabled again first
        if (bod_ready_i && brownout_detect_en_o) begin
          state_nxt = brownout_stack_pkg::ST_RUN;
        end
      end
      default: state_nxt = brownout_stack_pkg::ST_STARTUP;
    endcase
  end

  // any reset request sends the sequence back to start-up
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || reset_req_r) begin
      state_r <= brownout_stack_pkg::ST_STARTUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ===========================================================
  // stack and its events
  // ===========================================================
  return_stack u_stack (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .flush_i     (reset_req_r),
    .push_i      (push_i),
    .pop_i       (pop_i),
    .push_data_i (push_data_i),
    .top_data_o  (top_data_o),
    .overflow_o  (stack_ovf_ev),
    .underflow_o (stack_unf_ev)
  );

  // a flush on reset_req empties the stack; the flags below survive it
  assign stack_reset = stack_reset_enable_i & (stack_ovf_ev | stack_unf_ev);

  // overflow flag: the event is recorded even with stack reset disabled;
  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      stack_overflow_flag_o <= `FLAG_RST;
    end else if (stack_ovf_ev) begin
      stack_overflow_flag_o <= 1'b1;
    end else if (clear_overflow_i) begin
      stack_overflow_flag_o <= 1'b0;
    end
  end

  // underflow flag, same set-over-clear priority
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      stack_underflow_flag_o <= `FLAG_RST;
    end else if (stack_unf_ev) begin
      stack_underflow_flag_o <= 1'b1;
    end else if (clear_underflow_i) begin
      stack_underflow_flag_o <= 1'b0;
    end
  end

  // ===========================================================
  // merged reset request
  // ===========================================================
  // registered so even a one-cycle stack event gives a clean full-cycle
  // pulse; a brown-out keeps it high as long as the trip persists
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      reset_req_r <= 1'b0;
    end else begin
      reset_req_r <= bod_reset | stack_reset;
    end
  end

  assign reset_req_o = reset_req_r;

  // ===========================================================
  // status and hold outputs
  // ===========================================================
  // ready flag is a plain registered copy; software polls it before
  // relying on protection in the software-controlled mode
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      brownout_ready_flag_o <= 1'b0;
    end else begin
      brownout_ready_flag_o <= bod_ready_i;
    end
  end

  // registered enable to the comparator, so the analog side never sees
  // a glitch from the mode or state decode
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      brownout_detect_en_o <= 1'b0;
    end else begin
      brownout_detect_en_o <= detect_en;
    end
  end

  // holds decoded straight from the one-hot state
  assign startup_hold_o = in_state(state_r, brownout_stack_pkg::ST_STARTUP);
  assign wake_hold_o    = in_state(state_r, brownout_stack_pkg::ST_WAKE);
  assign sleeping_o     = in_state(state_r, brownout_stack_pkg::ST_SLEEP);

endmodule : brownout_and_stack_reset_ctrl

// ---- brownout_stack_defines.svh ----
// constants for the brown-out and stack reset controller
// assumes inclusion by bare name from the controller, the stack and the bench modules
`ifndef BROWNOUT_STACK_DEFINES_SVH
`define BROWNOUT_STACK_DEFINES_SVH

// brown-out mode configuration field codes
`define BOD_MODE_OFF      2'h0
`define BOD_MODE_SW       2'h1
`define BOD_MODE_NOSLEEP  2'h2
`define BOD_MODE_ALWAYS   2'h3

// return-address stack geometry
`define STACK_DEPTH       16
`define STACK_WIDTH       15
`define STACK_PTR_W       5
`define STACK_IDX_W       4

// reset values
`define STACK_PTR_RST     5'h00
`define FLAG_RST          1'b0

`endif

// ---- brownout_stack_pkg.sv ----
// types shared by the brown-out and stack reset controller
// assumes the defines header is on the include path
package brownout_stack_pkg;

  // power sequencing states, one-hot
  typedef enum logic [3:0] {
    ST_STARTUP = 4'h1,
    ST_RUN     = 4'h2,
    ST_SLEEP   = 4'h4,
    ST_WAKE    = 4'h8
  } power_state_e;

endpackage : brownout_stack_pkg

// ---- return_stack.sv ----
// 16-entry, 15-bit hardware return-address stack
// assumes push and pop are one-cycle pulses from the cpu, never both at once
`timescale 1ns/1ps
`include "brownout_stack_defines.svh"

module return_stack (
  input  wire logic                      sys_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      flush_i,
  input  wire logic                      push_i,
  input  wire logic                      pop_i,
  input  wire logic [`STACK_WIDTH-1:0]   push_data_i,
  output logic      [`STACK_WIDTH-1:0]   top_data_o,
  output logic                           overflow_o,
  output logic                           underflow_o
);

  logic [`STACK_WIDTH-1:0] mem_r [`STACK_DEPTH];
  logic [`STACK_PTR_W-1:0] ptr_r;
  logic                    full;
  logic                    empty;

  // pointer counts filled levels, 0 to 16
  assign full  = (ptr_r == 5'h10);
  assign empty = (ptr_r == `STACK_PTR_RST);
  // events: a push past level sixteen or a pop below level one
  assign overflow_o  = push_i & full;
  assign underflow_o = pop_i & empty;

  // ===========================================================
  // pointer
  // ===========================================================
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || flush_i) begin
      ptr_r <= `STACK_PTR_RST;
    end else if (push_i && !full) begin
      ptr_r <= ptr_r + 5'h01;
    end else if (pop_i && !empty) begin
      ptr_r <= ptr_r - 5'h01;
    end
  end

  // storage, a push beyond the top is dropped rather than wrapping
  always_ff @(posedge sys_clk_i) begin
    if (push_i && !full) begin
      mem_r[ptr_r[`STACK_IDX_W-1:0]] <= push_data_i;
    end
  end

  // top of stack registered, zero when empty
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || flush_i) begin
      top_data_o <= 15'h0000;
    end else if (push_i && !full) begin
      top_data_o <= push_data_i;
    end else if (pop_i && !empty) begin
      top_data_o <= (ptr_r > 5'h01) ? mem_r[ptr_r[`STACK_IDX_W-1:0] - 4'h2] : 15'h0000;
    end
  end

endmodule : return_stack

// ---- brownout_reset_checker.sv ----
// assertions on the ports of the brown-out and stack reset controller
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ps
module brownout_reset_checker (
  input wire logic       sys_clk_i,
  input wire logic       reset_n_i,
  input wire logic       stack_reset_enable_i,
  input wire logic       sw_brownout_enable_i,
  input wire logic [1:0] brownout_mode_cfg_i,
  input wire logic       sleep_i,
  input wire logic       bod_ready_i,
  input wire logic       bod_trip_i,
  input wire logic       push_i,
  input wire logic       pop_i,
  input wire logic       brownout_detect_en_o,
  input wire logic       brownout_ready_flag_o,
  input wire logic       stack_overflow_flag_o,
  input wire logic       stack_underflow_flag_o,
  input wire logic       reset_req_o,
  input wire logic       startup_hold_o,
  input wire logic       sleeping_o
);
  // ==========
  // properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_always_on: assert property (reset_n_i && brownout_mode_cfg_i == 2'h3 |=> brownout_detect_en_o)
    else $error("detector off in always-on mode");
  a_sleep_off: assert property (reset_n_i && brownout_mode_cfg_i == 2'h2 && sleeping_o |=> !brownout_detect_en_o)
    else $error("detector on in sleep");
  a_sw_follow: assert property (reset_n_i && brownout_mode_cfg_i == 2'h1
    |=> brownout_detect_en_o == $past(sw_brownout_enable_i)) else $error("detector ignores sw bit");
  a_off_quiet: assert property (brownout_mode_cfg_i == 2'h0 && !push_i && !pop_i |=> !reset_req_o)
    else $error("reset in mode off");
  a_sw_unready: assert property (brownout_mode_cfg_i == 2'h1 && !bod_ready_i && !push_i && !pop_i |=> !reset_req_o)
    else $error("reset before ready");
  a_trip_reset: assert property (reset_n_i && brownout_mode_cfg_i == 2'h3 && bod_ready_i && bod_trip_i |=> reset_req_o)
    else $error("trip gave no reset");
  a_ready_copy: assert property (reset_n_i |=> brownout_ready_flag_o == $past(bod_ready_i))
    else $error("ready flag wrong");
  a_ovf_reset: assert property ($rose(stack_overflow_flag_o) && $past(stack_reset_enable_i) |-> reset_req_o)
    else $error("overflow gave no reset");
  a_unf_reset: assert property ($rose(stack_underflow_flag_o) && $past(stack_reset_enable_i) |-> reset_req_o)
    else $error("underflow gave no reset");
  a_sw_startup: assert property (reset_n_i && brownout_mode_cfg_i == 2'h1 && startup_hold_o && !reset_req_o
    |=> !startup_hold_o) else $error("start-up held in sw mode");
  a_start_wait: assert property (reset_n_i && brownout_mode_cfg_i[1] && startup_hold_o && !bod_ready_i
    |=> startup_hold_o) else $error("start-up before ready");
endmodule : brownout_reset_checker

bind brownout_and_stack_reset_ctrl brownout_reset_checker u_chk (.sys_clk_i, .reset_n_i, .stack_reset_enable_i,
  .sw_brownout_enable_i, .brownout_mode_cfg_i, .sleep_i, .bod_ready_i, .bod_trip_i, .push_i, .pop_i,
  .brownout_detect_en_o, .brownout_ready_flag_o, .stack_overflow_flag_o, .stack_underflow_flag_o,
  .reset_req_o, .startup_hold_o, .sleeping_o);

// ---- supply_model.sv ----
// behavioural analog brown-out comparator
// assumes its enable comes from the controller's registered output
`timescale 1ns/1ps
module supply_model (
  input  wire logic       sys_clk_i,
  input  wire logic       detect_en_i,
  input  wire logic       supply_low_i,
  input  wire logic [2:0] delay_i,
  output logic            ready_o,
  output logic            trip_o
);
  logic [2:0] cnt_r = 3'h0;
  logic       tog_r = 1'b0;
  // ==========
  // ready comes delay_i cycles after enable, drops at once when disabled
  always @(posedge sys_clk_i) begin
    tog_r <= ~tog_r;
    if (!detect_en_i) cnt_r <= 3'h0;
    else if (cnt_r != delay_i) cnt_r <= cnt_r + 3'h1;
  end
  assign ready_o = detect_en_i && cnt_r == delay_i;
  // an unready comparator output means nothing, so it wanders
  assign trip_o  = ready_o ? supply_low_i : tog_r;
endmodule : supply_model

// ---- test_brownout_and_stack_reset_ctrl.sv ----
// self-checking bench for the brown-out and stack reset controller
// assumes supply_model stands in for the comparator; the bench plays the cpu
`timescale 1ns/1ps
`include "brownout_stack_defines.svh"
module test_brownout_and_stack_reset_ctrl;
  logic sys_clk_i, reset_n_i, stack_reset_enable_i, sw_brownout_enable_i, sleep_i, bod_ready_i, bod_trip_i;
  logic push_i, pop_i, clear_overflow_i, clear_underflow_i, supply_low, brownout_detect_en_o;
  logic brownout_ready_flag_o, stack_overflow_flag_o, stack_underflow_flag_o, reset_req_o;
  logic startup_hold_o, wake_hold_o, sleeping_o, ev_d;
  logic [1:0]              brownout_mode_cfg_i;
  logic [2:0]              delay;
  logic [`STACK_WIDTH-1:0] push_data_i, top_data_o;
  logic [`STACK_WIDTH-1:0] stk[$];
  logic [15:0]             notes[$];
  int                      n_mismatch = 0, total_checks = 0, i, j;
  brownout_and_stack_reset_ctrl u_dut (.sys_clk_i, .reset_n_i, .brownout_mode_cfg_i, .stack_reset_enable_i,
    .sw_brownout_enable_i, .sleep_i, .bod_ready_i, .bod_trip_i, .push_i, .pop_i, .push_data_i,
    .clear_overflow_i, .clear_underflow_i, .top_data_o, .brownout_detect_en_o, .brownout_ready_flag_o,
    .stack_overflow_flag_o, .stack_underflow_flag_o, .reset_req_o, .startup_hold_o, .wake_hold_o, .sleeping_o);
  supply_model u_supply (.sys_clk_i, .detect_en_i(brownout_detect_en_o), .supply_low_i(supply_low),
    .delay_i(delay), .ready_o(bod_ready_i), .trip_o(bod_trip_i));
  // ==========
  // helpers
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one push or pop; the expected reset and top go to the queue first
  task automatic op(input logic p, input logic [14:0] d);
    logic ov;
    ov = p ? (stk.size() == 16) : (stk.size() == 0);
    if (p && !ov) stk.push_back(d);
    if (!p && !ov) void'(stk.pop_back());
    notes.push_back({ov & stack_reset_enable_i, stk.size() != 0 ? stk[$] : 15'h0000});
    {push_i, pop_i, push_data_i} = {p, !p, d};
    step(1);
    {push_i, pop_i} = 2'h0;
    step(1);
    if (ov && stack_reset_enable_i) begin
      stk.delete(); // flush landed on the last edge; wait out the restart
      step(2);
    end
  endtask : op
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // ==========
  // result watcher: a stack event shows one edge later
  initial ev_d = 1'b0;
  always @(posedge sys_clk_i) begin
    if (ev_d) chk("reset_and_top", notes.pop_front(), {reset_req_o, top_data_o});
    ev_d <= push_i | pop_i;
  end
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  // ==========
  // scenarios
  initial begin
    {reset_n_i, push_i, pop_i, sleep_i, clear_overflow_i, clear_underflow_i, supply_low} = 7'h00;
    {brownout_mode_cfg_i, sw_brownout_enable_i, stack_reset_enable_i, push_data_i, delay} = {4'h5, 15'h0000, 3'h2};
    void'($urandom(32'hF23CC6C3));
    step(20);
    chk("startup_in_reset", 16'h0001, {reset_req_o, stack_overflow_flag_o, stack_underflow_flag_o, startup_hold_o});
    reset_n_i = 1'b1;
    step(2);
    chk("startup_sw_mode", 16'h0000, startup_hold_o);
    for (i = 0; i < 17; i++) op(1'b1, 15'($urandom));
    chk("overflow_flag", 16'h0001, stack_overflow_flag_o);
    stack_reset_enable_i = 1'b0;
    op(1'b0, 15'h0000);
    chk("underflow_no_reset", 16'h0001, stack_underflow_flag_o);
    {clear_overflow_i, clear_underflow_i} = 2'h3;
    step(1);
    {clear_overflow_i, clear_underflow_i, stack_reset_enable_i} = 3'h1;
    step(1);
    chk("flags_cleared", 16'h0000, {stack_overflow_flag_o, stack_underflow_flag_o});
    op(1'b0, 15'h0000);
    chk("underflow_flag", 16'h0001, stack_underflow_flag_o);
    for (i = 0; i < 6; i++) op(i != 2 && i != 4, 15'($urandom));
    // every mode under a low supply; the last pass has the sw bit off
    for (i = 0; i < 5; i++) begin
      brownout_mode_cfg_i = (i == 4) ? 2'h1 : 2'(i);
      sw_brownout_enable_i = (i < 4);
      delay = 3'($urandom_range(1, 6));
      supply_low = 1'b1;
      step(12);
      chk("brownout_reset", 16'(i inside {[1:3]}), reset_req_o);
      supply_low = 1'b0;
      step(12);
    end
    // sw bit on, so software mode has protection for sleep to leave alone
    sw_brownout_enable_i = 1'b1;
    for (i = 3; i > 0; i--) begin
      brownout_mode_cfg_i = 2'(i);
      step(12);
      sleep_i = 1'b1;
      step(4);
      chk("detect_in_sleep", 16'(i != 2), brownout_detect_en_o);
      chk("sleeping", 16'h0001, sleeping_o);
      sleep_i = 1'b0;
      step(1);
      chk("wake_hold", 16'(i == 2), wake_hold_o);
      for (j = 0; j < 20 && wake_hold_o !== 1'b0; j++) step(1);
      chk("ready_after_wake", 16'h0001, brownout_ready_flag_o);
    end
    // second reset mid-run in always-on mode: flags and stack clear, start-up waits for ready
    brownout_mode_cfg_i = 2'h3;
    reset_n_i = 1'b0;
    step(2);
    reset_n_i = 1'b1;
    step(2);
    chk("rerun_flags", 16'h0000, {reset_req_o, stack_overflow_flag_o, stack_underflow_flag_o});
    chk("rerun_top", 16'h0000, top_data_o);
    chk("rerun_wait", 16'h0001, startup_hold_o);
    step(12);
    chk("rerun_started", 16'h0000, startup_hold_o);
    final_report();
  end
endmodule : test_brownout_and_stack_reset_ctrl
